// >>> core/hysteresis_cell.sv
`timescale 1ns/1ps
`default_nettype none

module hysteresis_cell
	import relay_alarm_pkg::*;
(
	input  wire logic                     clock,
	input  wire logic                     rst_b,
	input  wire logic                     meas_update,
	input  wire logic signed [DATA_W-1:0] value,
	input  wire setpoint_t                sp,
	input  wire logic                     above_valid,
	input  wire logic                     below_valid,
	output logic                          active_ff
);

	localparam int EW = DATA_W + 2;

	logic signed [EW-1:0] v;
	logic signed [EW-1:0] a;
	logic signed [EW-1:0] b;
	logic signed [EW-1:0] h;
	logic signed [EW-1:0] a_minus_h;
	logic signed [EW-1:0] a_plus_h;
	logic signed [EW-1:0] b_minus_h;
	logic signed [EW-1:0] b_plus_h;
	logic                 both;
	logic                 inverted;
	logic                 set_normal;
	logic                 hold_normal;
	logic                 set_inv;
	logic                 hold_inv;
	logic                 nxt_active;

	// Widened so setpoint plus or minus hysteresis never wraps
	assign v         = EW'(value);
	assign a         = EW'(sp.above);
	assign b         = EW'(sp.below);
	assign h         = EW'(sp.hyst);
	assign a_minus_h = a - h;
	assign a_plus_h  = a + h;
	assign b_minus_h = b - h;
	assign b_plus_h  = b + h;

	assign both     = above_valid && below_valid;
	assign inverted = both && (a < b);

	// Activates at the exact setpoint, releases only past it by the hysteresis
	assign set_normal  = (above_valid && (v >= a)) || (below_valid && (v <= b));
	assign hold_normal = (above_valid && (v > a_minus_h)) ||
	                     (below_valid && (v < b_plus_h));
	// Inverted window: active inside the band, released at the exact crossing
	assign set_inv  = (v >= a_plus_h) && (v <= b_minus_h);
	assign hold_inv = (v > a) && (v < b);

	assign nxt_active = !meas_update ? active_ff :
	                    inverted     ? (active_ff ? hold_inv : set_inv) :
	                                   (active_ff ? hold_normal : set_normal);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			active_ff <= 1'b0;
		end else begin
			active_ff <= nxt_active;
		end
	end

endmodule

`default_nettype wire

// >>> core/quantity_select.sv
`timescale 1ns/1ps
`default_nettype none

module quantity_select
	import relay_alarm_pkg::*;
(
	input  wire source_t                  source,
	input  wire meas_t                    meas,
	input  wire logic                     device_error,
	input  wire logic                     live_data,
	output logic signed [DATA_W-1:0]      value,
	output logic                          is_status,
	output logic                          status_level
);

	// Quantity routed to the comparator
	assign value = (source == SRC_TEMPERATURE)       ? meas.temperature :
	               (source == SRC_WATER_CONTENT_PPM) ? meas.water_content_ppm :
	                                                   meas.relative_saturation;

	assign is_status = (source == SRC_FAULT_STATUS_SOURCE) ||
	                   (source == SRC_LIVE_DATA_STATUS_SOURCE);

	// Fault source is active in normal operation, live source while data exists
	assign status_level = (source == SRC_FAULT_STATUS_SOURCE) ? !device_error :
	                      (source == SRC_LIVE_DATA_STATUS_SOURCE) && live_data;

endmodule

`default_nettype wire

// >>> core/relay_alarm_ctrl.sv
// Behaviour
// - Normal window: passive between setpoints, active outside
// - Inverted setpoints: passive outside the band
// - Either setpoint alone, or both, may be used
// - Activation at the exact setpoint crossing
// - Release only past setpoint by hysteresis
// - Inverted setpoints reverse the hysteresis direction
// - Fault source: active normally, released on error
// - Live source: active only while data available
// - Per-relay enable gates normal operation
// - All relays disabled after reset
// - Source: saturation, temperature, ppm, fault, live
// - Test mode forces relays ignoring enables
// - Test command sets states; clearing ends test
// - Button activates relay; lamp shows relay state
// - Slot one holds relays 1-2, slot two 3-4
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module relay_alarm_ctrl
	import relay_alarm_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire meas_t             meas,
	input  wire logic              meas_update,
	input  wire logic              device_error,
	input  wire logic              live_data,
	input  wire logic [1:0]        slot1_button,
	input  wire logic [1:0]        slot2_button,
	output logic      [1:0]        slot1_relay,
	output logic      [1:0]        slot2_relay,
	output logic      [1:0]        slot1_lamp,
	output logic      [1:0]        slot2_lamp
);

	relay_cfg_t                cfg_ff [NUM_RELAYS];
	setpoint_t                 sp_ff  [NUM_RELAYS];
	mode_t                     mode_ff;
	mode_t                     nxt_mode;
	logic [NUM_RELAYS-1:0]     test_state_ff;
	logic [NUM_RELAYS-1:0]     nxt_test_state;
	logic [NUM_RELAYS-1:0]     relay_ff;
	logic [NUM_RELAYS-1:0]     nxt_relay;
	logic [NUM_RELAYS-1:0]     lamp_ff;
	logic [DATA_W-1:0]         rdata_ff;
	logic [DATA_W-1:0]         nxt_rdata;

	logic [NUM_RELAYS-1:0]     chan_state;
	logic [NUM_RELAYS-1:0]     hyst_state;
	logic [NUM_RELAYS-1:0]     status_level;
	logic [NUM_RELAYS-1:0]     is_status;
	logic [NUM_RELAYS-1:0]     enabled;
	logic [NUM_RELAYS-1:0]     button;
	logic [NUM_RELAYS-1:0]     normal_drive;
	logic [NUM_RELAYS-1:0]     test_drive;

	logic                      in_relay_block;
	logic [1:0]                relay_idx;
	logic [1:0]                field_sel;
	logic                      wr_test;
	logic [DATA_W-1:0]         relay_rd_word;
	logic [DATA_W-1:0]         status_word;
	logic [DATA_W-1:0]         test_word;
	logic [DATA_W-1:0]         rd_sel;

	// Address decode
	assign in_relay_block = !reg_addr[4];
	assign relay_idx      = reg_addr[3:2];
	assign field_sel      = reg_addr[1:0];
	assign wr_test        = reg_wr && (reg_addr == TEST_ADDR);

	// Relays 1-2 sit in slot one, relays 3-4 in slot two
	assign button = {slot2_button, slot1_button};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_RELAYS; gi++) begin : g_relay
			logic signed [DATA_W-1:0] value;
			logic                     wr_here;

			assign wr_here = reg_wr && in_relay_block && (relay_idx == 2'(gi));

			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					cfg_ff[gi] <= CFG_RESET;
				end else if (wr_here && (field_sel == FIELD_CFG)) begin
					cfg_ff[gi] <= relay_cfg_t'(reg_wdata[$bits(relay_cfg_t)-1:0]);
				end
			end

			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					sp_ff[gi] <= SP_RESET;
				end else if (wr_here) begin
					if (field_sel == FIELD_ABOVE) begin
						sp_ff[gi].above <= reg_wdata;
					end
					if (field_sel == FIELD_BELOW) begin
						sp_ff[gi].below <= reg_wdata;
					end
					if (field_sel == FIELD_HYST) begin
						sp_ff[gi].hyst <= reg_wdata;
					end
				end
			end

			quantity_select u_select (
				.source       (cfg_ff[gi].source),
				.meas         (meas),
				.device_error (device_error),
				.live_data    (live_data),
				.value        (value),
				.is_status    (is_status[gi]),
				.status_level (status_level[gi])
			);

			hysteresis_cell u_hyst (
				.clock       (clock),
				.rst_b       (rst_b),
				.meas_update (meas_update),
				.value       (value),
				.sp          (sp_ff[gi]),
				.above_valid (cfg_ff[gi].above_valid),
				.below_valid (cfg_ff[gi].below_valid),
				.active_ff   (hyst_state[gi])
			);

			// Status sources follow the device state directly
			assign chan_state[gi] = is_status[gi] ? status_level[gi] : hyst_state[gi];
			assign enabled[gi]    = cfg_ff[gi].enable;
		end
	endgenerate

	// Mode control: writing the test register with the mode bit set
	// enters test mode, writing it clear returns to normal control
	always_comb begin
		nxt_mode       = mode_ff;
		nxt_test_state = test_state_ff;
		unique case (mode_ff)
			MODE_NORMAL: begin
				if (wr_test && reg_wdata[TEST_MODE_BIT]) begin
					nxt_mode       = MODE_TEST;
					nxt_test_state = reg_wdata[TEST_STATE_LSB +: NUM_RELAYS];
				end
			end
			MODE_TEST: begin
				if (wr_test) begin
					nxt_mode       = reg_wdata[TEST_MODE_BIT] ? MODE_TEST : MODE_NORMAL;
					nxt_test_state = reg_wdata[TEST_MODE_BIT] ?
					                 reg_wdata[TEST_STATE_LSB +: NUM_RELAYS] : STATE_RESET;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mode_ff       <= MODE_RESET;
			test_state_ff <= STATE_RESET;
		end else begin
			mode_ff       <= nxt_mode;
			test_state_ff <= nxt_test_state;
		end
	end

	// Disabled relays stay released outside test mode unless their push button is pressed
	assign normal_drive = chan_state & enabled;
	// Test states and push buttons ignore the enable settings
	assign test_drive   = (mode_ff == MODE_TEST) ? test_state_ff : STATE_RESET;
	assign nxt_relay    = (mode_ff == MODE_TEST) ? (test_drive | button) :
	                                               (normal_drive | button);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			relay_ff <= STATE_RESET;
			lamp_ff  <= STATE_RESET;
		end else begin
			relay_ff <= nxt_relay;
			lamp_ff  <= nxt_relay;
		end
	end

	// Read path
	assign relay_rd_word = (field_sel == FIELD_CFG)   ?
	                       DATA_W'(cfg_ff[relay_idx]) :
	                       (field_sel == FIELD_ABOVE) ? sp_ff[relay_idx].above :
	                       (field_sel == FIELD_BELOW) ? sp_ff[relay_idx].below :
	                                                    sp_ff[relay_idx].hyst;

	assign test_word = DATA_W'({test_state_ff, (mode_ff == MODE_TEST)});

	assign status_word = DATA_W'({button,
	                              (mode_ff == MODE_TEST),
	                              chan_state,
	                              relay_ff});

	assign rd_sel = in_relay_block            ? relay_rd_word :
	                (reg_addr == TEST_ADDR)   ? test_word :
	                (reg_addr == STATUS_ADDR) ? status_word :
	                                            '0;

	// Read data stands only in the cycle after the strobe
	assign nxt_rdata = reg_rd ? rd_sel : '0;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata   = rdata_ff;
	assign slot1_relay = relay_ff[1:0];
	assign slot2_relay = relay_ff[3:2];
	assign slot1_lamp  = lamp_ff[1:0];
	assign slot2_lamp  = lamp_ff[3:2];

endmodule

`default_nettype wire

// >>> core/relay_alarm_pkg.sv
`default_nettype none

package relay_alarm_pkg;

	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 5;
	localparam int NUM_RELAYS = 4;

	// Per-relay block: address bit 4 low, bits 3:2 relay index, bits 1:0 field
	localparam logic [1:0] FIELD_CFG   = 2'h0;
	localparam logic [1:0] FIELD_ABOVE = 2'h1;
	localparam logic [1:0] FIELD_BELOW = 2'h2;
	localparam logic [1:0] FIELD_HYST  = 2'h3;
	localparam logic [4:0] TEST_ADDR   = 5'h10;
	localparam logic [4:0] STATUS_ADDR = 5'h11;

	// Test register fields
	localparam int TEST_MODE_BIT  = 0;
	localparam int TEST_STATE_LSB = 1;
	// Status register fields
	localparam int STAT_RELAY_LSB = 0;
	localparam int STAT_CHAN_LSB  = 4;
	localparam int STAT_TEST_BIT  = 8;
	localparam int STAT_BTN_LSB   = 9;

	typedef enum logic [2:0] {
		SRC_RELATIVE_SATURATION    = 3'h0,
		SRC_TEMPERATURE            = 3'h1,
		SRC_WATER_CONTENT_PPM      = 3'h2,
		SRC_FAULT_STATUS_SOURCE    = 3'h3,
		SRC_LIVE_DATA_STATUS_SOURCE = 3'h4
	} source_t;

	typedef enum logic {
		MODE_NORMAL = 1'b0,
		MODE_TEST   = 1'b1
	} mode_t;

	typedef struct packed {
		logic    below_valid;
		logic    above_valid;
		logic    enable;
		source_t source;
	} relay_cfg_t;

	typedef struct packed {
		logic signed [DATA_W-1:0] above;
		logic signed [DATA_W-1:0] below;
		logic signed [DATA_W-1:0] hyst;
	} setpoint_t;

	typedef struct packed {
		logic signed [DATA_W-1:0] relative_saturation;
		logic signed [DATA_W-1:0] temperature;
		logic signed [DATA_W-1:0] water_content_ppm;
	} meas_t;

	localparam relay_cfg_t CFG_RESET   = '{1'b0, 1'b0, 1'b0, SRC_RELATIVE_SATURATION};
	localparam setpoint_t  SP_RESET    = '0;
	localparam mode_t      MODE_RESET  = MODE_NORMAL;
	localparam logic [3:0] STATE_RESET = 4'h0;

endpackage

`default_nettype wire

// >>> verification/alarm_contacts.sv
`timescale 1ns/1ps
`default_nettype none

module alarm_contacts (
	input  wire logic [3:0] coil,
	output logic      [3:0] no_closed,
	output logic      [3:0] nc_closed
);
	// Alarm loop side: an energised coil closes common to NO, a dead one to NC
	assign no_closed = coil;
	assign nc_closed = ~coil;
endmodule

`default_nettype wire

// >>> verification/relay_alarm_sva.sv
`timescale 1ns/1ps
`default_nettype none

module relay_alarm_sva
	import relay_alarm_pkg::*;
(
	input wire logic              clock,
	input wire logic              rst_b,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire meas_t             meas,
	input wire logic              meas_update,
	input wire logic              device_error,
	input wire logic              live_data,
	input wire logic [1:0]        slot1_button,
	input wire logic [1:0]        slot2_button,
	input wire logic [1:0]        slot1_relay,
	input wire logic [1:0]        slot2_relay,
	input wire logic [1:0]        slot1_lamp,
	input wire logic [1:0]        slot2_lamp
);
	wire logic [3:0] relays      = {slot2_relay, slot1_relay};
	wire logic [3:0] buttons     = {slot2_button, slot1_button};
	wire logic [3:0] test_states = reg_wdata[TEST_STATE_LSB +: 4];
	wire logic       test_wr     = reg_wr && reg_addr == TEST_ADDR;
	wire logic       status_rd   = reg_rd && reg_addr == STATUS_ADDR;
	logic            test_on_ff;

	// Mirror of the test mode flag for the status check
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			test_on_ff <= 1'b0;
		else if (test_wr)
			test_on_ff <= reg_wdata[TEST_MODE_BIT];
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence quiet_inputs;
		!reg_wr && !meas_update && $stable(buttons) && $stable(device_error) && $stable(live_data);
	endsequence

	a_reset_clears_relays: assert property ($rose(rst_b) |-> relays == 4'h0)
		else $error("relay active right after reset");
	a_lamp_shows_relay: assert property ({slot2_lamp, slot1_lamp} == relays)
		else $error("lamp differs from relay");
	a_button_drives_relay: assert property (|buttons |=> ($past(buttons) & ~relays) == 4'h0)
		else $error("pressed button left relay released");
	a_test_forces_state: assert property (test_wr && reg_wdata[TEST_MODE_BIT] |-> ##2
		relays == ($past(test_states, 2) | $past(buttons)))
		else $error("test states not forced on relays");
	a_status_relay_order: assert property (status_rd |=> reg_rdata[3:0] == $past(relays))
		else $error("status relay bits wrong");
	a_status_test_flag: assert property (status_rd |=>
		reg_rdata[STAT_TEST_BIT] == $past(test_on_ff))
		else $error("status test flag wrong");
	a_status_button_bits: assert property (status_rd |=>
		reg_rdata[STAT_BTN_LSB +: 4] == $past(buttons))
		else $error("status button bits wrong");
	a_relays_hold_steady: assert property (quiet_inputs [*3] |-> $stable(relays))
		else $error("relay moved without a cause");

	c_test_mode: cover property (test_wr && reg_wdata[TEST_MODE_BIT]);
	c_quantity_rise: cover property (meas_update ##2 $rose(slot1_relay[0]));
	c_fault_drop: cover property ($rose(device_error) ##1 $fell(slot2_relay[1]));
endmodule

bind relay_alarm_ctrl relay_alarm_sva i_sva (
	.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
	.meas_update(meas_update), .device_error(device_error), .live_data(live_data),
	.slot1_button(slot1_button), .slot2_button(slot2_button), .slot1_relay(slot1_relay),
	.slot2_relay(slot2_relay), .slot1_lamp(slot1_lamp), .slot2_lamp(slot2_lamp));

`default_nettype wire

// >>> verification/test_relay_setpoint_alarm_logic.sv
`timescale 1ns/1ps
`default_nettype none

module test_relay_setpoint_alarm_logic
	import relay_alarm_pkg::*;
;
	logic              clock = 1'b0;
	logic              rst_b = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	meas_t             meas = '0;
	logic              meas_update = 1'b0;
	logic              device_error = 1'b0;
	logic              live_data = 1'b0;
	logic [1:0]        slot1_button = '0;
	logic [1:0]        slot2_button = '0;
	logic [1:0]        slot1_relay, slot2_relay, slot1_lamp, slot2_lamp;
	logic [3:0]        no_closed, nc_closed;
	int                err_total = 0;
	int                total_checks = 0;

	always #5 clock = ~clock;

	relay_alarm_ctrl i_dut (
		.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas(meas),
		.meas_update(meas_update), .device_error(device_error), .live_data(live_data),
		.slot1_button(slot1_button), .slot2_button(slot2_button), .slot1_relay(slot1_relay),
		.slot2_relay(slot2_relay), .slot1_lamp(slot1_lamp), .slot2_lamp(slot2_lamp));

	alarm_contacts i_contacts (.coil({slot2_relay, slot1_relay}), .no_closed(no_closed),
		.nc_closed(nc_closed));

	task automatic end_of_test();
		if (err_total == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Relay bit n-1 is relay n; lamps and both contact sets checked alongside
	task automatic chk_relays(input logic [3:0] exp);
		#1;
		chk_data({no_closed, nc_closed, slot2_lamp, slot1_lamp, slot2_relay, slot1_relay},
			{exp, ~exp, exp, exp});
		@(posedge clock);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk_data(reg_rdata, e);
		@(posedge clock);
	endtask

	task automatic cfg(input logic [1:0] r, input logic [15:0] c, ab, bl, hy);
		wr({1'b0, r, FIELD_ABOVE}, ab);
		wr({1'b0, r, FIELD_BELOW}, bl);
		wr({1'b0, r, FIELD_HYST}, hy);
		wr({1'b0, r, FIELD_CFG}, c);
	endtask

	// New sample on all three quantities, relay checked two edges later
	task automatic mchk(input logic [15:0] rs, t, ppm, input logic [3:0] e);
		meas <= '{rs, t, ppm};
		meas_update <= 1'b1;
		@(posedge clock);
		meas_update <= 1'b0;
		@(posedge clock);
		chk_relays(e);
	endtask

	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		for (int n = 0; n < 4; n++)
			rd({1'b0, n[1:0], FIELD_CFG}, 16'h0000);
		rd(5'h12, 16'h0000);
		wr(5'h1F, 16'hFFFF);
		rd(5'h1F, 16'h0000);
		cfg(2'h0, 16'h0038, 16'h003C, 16'h0014, 16'h0005);
		mchk(16'h0028, 16'h0000, 16'h0000, 4'h0);
		mchk(16'h003C, 16'h0000, 16'h0000, 4'h1);
		mchk(16'h0038, 16'h0000, 16'h0000, 4'h1);
		mchk(16'h0037, 16'h0000, 16'h0000, 4'h0);
		mchk(16'h0014, 16'h0000, 16'h0000, 4'h1);
		mchk(16'h0018, 16'h0000, 16'h0000, 4'h1);
		mchk(16'h0019, 16'h0000, 16'h0000, 4'h0);
		cfg(2'h1, 16'h0039, 16'h0014, 16'h003C, 16'h0005);
		mchk(16'h0019, 16'h0028, 16'h0000, 4'h2);
		mchk(16'h0019, 16'h0014, 16'h0000, 4'h0);
		mchk(16'h0019, 16'h0018, 16'h0000, 4'h0);
		mchk(16'h0019, 16'h0019, 16'h0000, 4'h2);
		mchk(16'h0019, 16'h003C, 16'h0000, 4'h0);
		cfg(2'h2, 16'h001A, 16'h0064, 16'h0000, 16'h000A);
		mchk(16'h0019, 16'h003C, 16'h0063, 4'h0);
		mchk(16'h0019, 16'h003C, 16'h0064, 4'h4);
		mchk(16'h0019, 16'h003C, 16'h005B, 4'h4);
		mchk(16'h0019, 16'h003C, 16'h005A, 4'h0);
		wr(5'h0A, 16'h0032);
		wr(5'h08, 16'h002A);
		mchk(16'h0019, 16'h003C, 16'h0033, 4'h0);
		mchk(16'h0019, 16'h003C, 16'h0032, 4'h4);
		mchk(16'h0019, 16'h003C, 16'h003B, 4'h4);
		mchk(16'h0019, 16'h003C, 16'h003C, 4'h0);
		wr(5'h0C, 16'h000B);
		chk_relays(4'h8);
		device_error <= 1'b1;
		@(posedge clock);
		chk_relays(4'h0);
		device_error <= 1'b0;
		wr(5'h0C, 16'h000C);
		chk_relays(4'h0);
		live_data <= 1'b1;
		@(posedge clock);
		chk_relays(4'h8);
		live_data <= 1'b0;
		@(posedge clock);
		chk_relays(4'h0);
		wr(5'h00, 16'h0030);
		mchk(16'h0046, 16'h003C, 16'h005A, 4'h0);
		rd(STATUS_ADDR, 16'h0010);
		for (int i = 0; i < 16; i++) begin
			wr(TEST_ADDR, {11'h000, i[3:0], 1'b1});
			chk_relays(i[3:0]);
		end
		rd(STATUS_ADDR, 16'h011F);
		wr(TEST_ADDR, 16'h0000);
		chk_relays(4'h0);
		slot2_button <= 2'b10;
		@(posedge clock);
		chk_relays(4'h8);
		rd(STATUS_ADDR, 16'h1018);
		slot2_button <= 2'b00;
		slot1_button <= 2'b01;
		@(posedge clock);
		chk_relays(4'h1);
		slot1_button <= 2'b00;
		@(posedge clock);
		chk_relays(4'h0);
		end_of_test();
	end

	initial begin
		repeat (5000) @(posedge clock);
		err_total++;
		end_of_test();
	end
endmodule

`default_nettype wire
